// file: dv/modbus_rtu_slave_function_handler_test.sv
// Self-checking bench for the query handler with a register store partner.
// Assumes a 40 MHz clock and a byte-wide receive strobe.
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module modbus_rtu_slave_function_handler_test
  import mrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, rx_valid_i = 1'b0, rx_err_i = 1'b0, rx_eof_i = 1'b0;
  logic [7:0]  slave_addr_i = 8'h00, rx_data_i = 8'h00, tx_data_o, addr_xor = 8'h00;
  logic        tx_valid_o, tx_ready_i, reg_rd_o, reg_wr_o, reg_ack_i, reg_err_i, busy_o, drop_o;
  logic [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic [31:0] wr_log;
  logic [1:0]  ph_q = 2'h0;
  int          fail_count = 0, checks = 0, drops = 0, err_at = -1;
  byte unsigned q[$], exp[$], got[$];

  mrs_func_handler i_mrs_func_handler (.clk_i, .sys_rst_i, .slave_addr_i, .rx_valid_i, .rx_data_i, .rx_err_i,
    .rx_eof_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .reg_rd_o, .reg_wr_o, .reg_addr_o, .reg_wdata_o,
    .reg_ack_i, .reg_err_i, .reg_rdata_i, .busy_o, .drop_o);
  mrs_store_model i_mrs_store_model (.clk_i, .sys_rst_i, .rd_i(reg_rd_o), .wr_i(reg_wr_o),
    .addr_i(reg_addr_o), .ack_o(reg_ack_i), .err_o(reg_err_i), .rdata_o(reg_rdata_i));

  always #12.5 clk_i = ~clk_i;
  // Transmitter stalls one cycle in four
  always @(posedge clk_i) ph_q <= #1 ph_q + 2'h1;
  assign tx_ready_i = ph_q != 2'h0;
  // Observers of sent bytes, drops and stored writes
  always @(posedge clk_i) if (tx_valid_o === 1'b1 && tx_ready_i) got.push_back(tx_data_o);
  always @(posedge clk_i) if (drop_o === 1'b1) drops++;
  always @(posedge clk_i) if (reg_wr_o === 1'b1 && reg_ack_i) wr_log = {reg_addr_o, reg_wdata_o};

  function automatic int crc(byte unsigned f[$]);
    int c;
    c = 32'hffff;
    foreach (f[i])
    begin
      c ^= f[i];
      repeat (8) c = c[0] ? (c >> 1) ^ 32'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic seal(ref byte unsigned x[$]);
    int c;
    c = crc(x);
    x.push_back(8'(c));
    x.push_back(8'(c >> 8));
  endtask
  task automatic frm(input logic [7:0] a, f, input logic [15:0] p, v);
    q = {a, f, p[15:8], p[7:0], v[15:8], v[7:0]};
    seal(q);
  endtask
  task automatic exc(input logic [7:0] a, f, c);
    exp = {a, f | MRS_EXC_FLAG, c};
    seal(exp);
  endtask
  // Sends the query, waits for the handler to settle, compares the reply
  task automatic go(input int bad);
    int d0;
    d0 = drops;
    got = {};
    @(posedge clk_i) #1;
    slave_addr_i = q[0] ^ addr_xor;
    foreach (q[i])
    begin
      rx_valid_i = 1'b1;
      rx_data_i = q[i];
      rx_err_i = (i == err_at);
      @(posedge clk_i) #1;
    end
    rx_valid_i = 1'b0;
    rx_err_i = 1'b0;
    rx_eof_i = 1'b1;
    @(posedge clk_i) #1;
    rx_eof_i = 1'b0;
    repeat (3) @(posedge clk_i) #1;
    for (int i = 0; i < 400 && busy_o !== 1'b0; i++) @(posedge clk_i) #1;
    `CHK(got.size(), exp.size())
    foreach (exp[i]) `CHK(got[i], exp[i])
    `CHK(drops - d0, bad)
  endtask
  task automatic report_and_stop;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #1ms;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    logic [15:0] s, w;
    int ns[5] = '{1, 4, 16, 0, 17};
    void'($urandom(32'he9b0dde3));
    repeat (6) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    // Single write stored and echoed
    w = 16'($urandom);
    s = {4'h4, 12'($urandom)};
    frm(8'h02, 8'h06, s, w);
    exp = q;
    go(0);
    `CHK(wr_log, {s, w})
    // Poisoned byte and foreign station address: dropped, nothing stored
    frm(8'h02, 8'h06, 16'h4001, 16'h1234);
    exp = {};
    err_at = 3;
    go(1);
    err_at = -1;
    addr_xor = 8'h01;
    go(1);
    addr_xor = 8'h00;
    `CHK(wr_log, {s, w})
    // Reads at both count limits and beyond them
    foreach (ns[k])
    begin
      s = {4'h4, 12'($urandom)};
      frm(8'h01, 8'h03, s, 16'(ns[k]));
      if (ns[k] >= 1 && ns[k] <= MRS_MAX_REGS)
      begin
        exp = {8'h01, 8'h03, 8'(2 * ns[k])};
        for (int i = 0; i < ns[k]; i++)
        begin
          w = 16'(s + i) ^ 16'h5a5a;
          exp.push_back(w[15:8]);
          exp.push_back(w[7:0]);
        end
        seal(exp);
      end
      else
        exc(8'h01, 8'h03, 8'h03);
      go(0);
    end
    // Diagnosis echo, then an unsupported sub-function
    frm(8'h03, 8'h08, 16'h0000, w);
    exp = q;
    go(0);
    frm(8'h03, 8'h08, 16'h0001, w);
    exc(8'h03, 8'h08, 8'h01);
    go(0);
    // Broadcast write is stored but never answered
    s = {4'h4, 12'($urandom)};
    w = 16'($urandom);
    frm(8'h00, 8'h06, s, w);
    exp = {};
    go(0);
    `CHK(wr_log, {s, w})
    // Unsupported function code
    frm(8'h02, 8'h10, s, w);
    exc(8'h02, 8'h10, 8'h01);
    go(0);
    // Store refuses the write
    frm(8'h01, 8'h06, 16'h021e, 16'hffff);
    exc(8'h01, 8'h06, 8'h04);
    go(0);
    // Corrupted check field is discarded
    frm(8'h02, 8'h06, s, w);
    q[7] = q[7] ^ 8'h01;
    exp = {};
    go(1);
    report_and_stop();
  end
endmodule

// file: dv/mrs_func_monitor.sv
// Port-level assertions for the query handler.
// Assumes it is bound into mrs_func_handler; one clock domain.
module mrs_func_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Observed ports
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_ready_i,
  input wire logic        reg_rd_o,
  input wire logic        reg_wr_o,
  input wire logic [15:0] reg_addr_o,
  input wire logic        reg_ack_i,
  input wire logic        reg_err_i,
  input wire logic        busy_o,
  input wire logic        drop_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Read granted, released for one cycle, next read raised
  sequence s_rd_step;
    reg_rd_o && reg_ack_i && !reg_err_i ##1 !reg_rd_o ##1 reg_rd_o;
  endsequence
  // Response byte offered but not taken
  sequence s_tx_stall;
    tx_valid_o && !tx_ready_i;
  endsequence
  a_tx_byte_hold: assert property (s_tx_stall |=> tx_valid_o && $stable(tx_data_o)) else $error("tx byte moved");
  a_rd_ascend: assert property (s_rd_step |-> reg_addr_o == $past(reg_addr_o, 2) + 16'h1) else $error("read order");
  a_rd_addr_hold: assert property (reg_rd_o && !reg_ack_i |=> reg_rd_o && $stable(reg_addr_o)) else $error("rd moved");
  a_rd_release: assert property (reg_rd_o && reg_ack_i |=> !reg_rd_o) else $error("rd held after ack");
  a_wr_release: assert property (reg_wr_o && reg_ack_i |=> !reg_wr_o ##1 !reg_wr_o) else $error("wr repeated");
  a_rw_exclusive: assert property (!(reg_rd_o && reg_wr_o)) else $error("rd and wr together");
  a_drop_pulse: assert property (drop_o |=> !drop_o) else $error("drop longer than one cycle");
  a_drop_silent: assert property (drop_o |-> !busy_o && !tx_valid_o) else $error("dropped frame answered");
  a_idle_quiet: assert property (!busy_o |-> !tx_valid_o && !reg_rd_o && !reg_wr_o) else $error("idle activity");
endmodule

bind mrs_func_handler mrs_func_monitor i_mrs_func_monitor (.clk_i, .sys_rst_i, .tx_valid_o, .tx_data_o,
  .tx_ready_i, .reg_rd_o, .reg_wr_o, .reg_addr_o, .reg_ack_i, .reg_err_i, .busy_o, .drop_o);

// file: dv/mrs_store_model.sv
// Register store partner answering the handler's read and write requests.
// Assumes requests hold until acknowledged, one at a time.
module mrs_store_model #(
  parameter logic [15:0] ERR_ADDR = 16'h021e
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Store port
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [15:0] addr_i,
  output logic             ack_o,
  output logic             err_o,
  output logic [15:0]      rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_q;
  // Wait follows the address so prompt and slow answers both occur
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i)
      wait_q <= 2'h0;
    else
      wait_q <= (rd_i || wr_i) && !ack_o ? wait_q + 2'h1 : 2'h0;
  // Data bus shows the inverse when not answering
  assign ack_o   = (rd_i || wr_i) && wait_q == addr_i[1:0];
  assign err_o   = ack_o && addr_i == ERR_ADDR;
  assign rdata_o = ack_o ? addr_i ^ 16'h5a5a : ~addr_i;
endmodule

// file: pkg/mrs_crc_if.sv
// Carrier between the handler and one check-code engine.
// Assumes the user side drives clear, enable and byte in the handler's clock.
interface mrs_crc_if;
  logic       clr;
  logic       en;
  logic [7:0] data;
  logic [15:0] crc;

  modport eng  (input clr, input en, input data, output crc);
  modport user (output clr, output en, output data, input crc);
endinterface

// file: pkg/mrs_pkg.sv
// Constants shared by the query handler and its check-code engine.
// Assumes a byte-wide receiver and transmitter on the same clock as the handler.
// What this block does
// R01: Read request: start address, up to sixteen registers
// R02: Read words returned in ascending address order
// R03: Master sends address, function, start, count, check
// R04: Read reply: address, function, byte count, words
// R05: Master reads both halves together
// R06: Single write stores value, echoes request unchanged
// R07: Master sends address, function, register, value, check
// R08: Master writes paired halves with multi-write; the handler answers function 10h with exception 01h
// R09: Diagnosis supports only sub-function zero
// R10: Diagnosis reply is identical to the query
// R11: Failed single write answers exception code 04h
// R12: Exception function equals query function plus 80h
// R13: Nonzero diagnosis sub-function gets exception 01h
// R14: Zero or oversized register count gets 03h
// R15: Bad check field discards query silently
// R16: Check field sent low byte first
package mrs_pkg;
  localparam logic [7:0]  MRS_FC_READ       = 8'h03;
  localparam logic [7:0]  MRS_FC_WRITE      = 8'h06;
  localparam logic [7:0]  MRS_FC_DIAG       = 8'h08;
  localparam logic [7:0]  MRS_EXC_FLAG      = 8'h80;
  localparam logic [7:0]  MRS_EXC_BAD_FUNC  = 8'h01;
  localparam logic [7:0]  MRS_EXC_BAD_DATA  = 8'h03;
  localparam logic [7:0]  MRS_EXC_SLAVE_ERR = 8'h04;
  localparam logic [7:0]  MRS_BCAST_ADDR    = 8'h00;
  localparam logic [15:0] MRS_DIAG_ECHO_SUB = 16'h0000;
  localparam logic [15:0] MRS_CRC_INIT      = 16'hffff;
  localparam logic [15:0] MRS_CRC_POLY      = 16'ha001;
  localparam int          MRS_MAX_REGS      = 16;
  localparam int          MRS_QRY_LEN       = 8;
  localparam int          MRS_MIN_LEN       = 4;
  localparam int          MRS_MAX_FRAME     = 256;
  localparam logic [5:0]  MRS_ECHO_LEN      = 6'h08;
  localparam logic [5:0]  MRS_EXC_LEN       = 6'h05;
  localparam logic [5:0]  MRS_RD_HDR_LEN    = 6'h05;

  typedef enum logic [1:0] {MRS_M_ECHO, MRS_M_EXC, MRS_M_READ} mrs_mode_t;
  typedef enum logic [2:0] {MRS_S_IDLE, MRS_S_RD, MRS_S_WR, MRS_S_SEND} mrs_state_t;
endpackage

// file: verilog/mrs_crc16.sv
// Byte-serial CRC-16 engine, one byte folded in per enabled cycle.
// Assumes clear and enable are never raised together; clear wins if they are.
module mrs_crc16
  import mrs_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // Engine side of the carrier
  mrs_crc_if.eng    crc_if
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;

  // Eight shift-and-fold steps unrolled by the loop
  function automatic logic [15:0] fold_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      if (r[0])
        r = (r >> 1) ^ MRS_CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  assign crc_d      = crc_if.clr ? MRS_CRC_INIT : (crc_if.en ? fold_byte(crc_q, crc_if.data) : crc_q);
  assign crc_if.crc = crc_q;

  // Running remainder
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      crc_q <= MRS_CRC_INIT;
    else
      crc_q <= crc_d;
  end
endmodule

// file: verilog/mrs_func_handler.sv
// Slave query handler for read-registers, single write and diagnosis echo.
// Assumes a receiver that strobes bytes and flags end of frame on line silence,
// a transmitter with valid/ready, and a register store with request/ack.
module mrs_func_handler
  import mrs_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // Station address
  input  wire logic [7:0]  slave_addr_i,
  // Received bytes from the serial receiver
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_err_i,
  input  wire logic        rx_eof_i,
  // Response bytes to the serial transmitter
  output logic             tx_valid_o,
  output logic [7:0]       tx_data_o,
  input  wire logic        tx_ready_i,
  // Register store port
  output logic             reg_rd_o,
  output logic             reg_wr_o,
  output logic [15:0]      reg_addr_o,
  output logic [15:0]      reg_wdata_o,
  input  wire logic        reg_ack_i,
  input  wire logic        reg_err_i,
  input  wire logic [15:0] reg_rdata_i,
  // Status
  output logic             busy_o,
  output logic             drop_o
);
  mrs_crc_if rx_crc ();
  mrs_crc_if tx_crc ();

  mrs_crc16 u_rx_crc (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .crc_if(rx_crc));
  mrs_crc16 u_tx_crc (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .crc_if(tx_crc));

  mrs_state_t  state_q;
  mrs_mode_t   mode_q;
  logic [7:0]  qbuf_q [MRS_QRY_LEN];
  logic [15:0] rdbuf_q [MRS_MAX_REGS];
  logic [8:0]  rx_cnt_q;
  logic        rx_bad_q;
  logic        bcast_q;
  logic [7:0]  exc_q;
  logic [3:0]  rd_idx_q;
  logic [5:0]  tx_idx_q;
  logic [5:0]  tx_len_q;
  logic        tx_valid_q;
  logic [7:0]  tx_data_q;
  logic        reg_rd_q;
  logic        reg_wr_q;
  logic [15:0] reg_addr_q;
  logic        drop_q;
  logic        busy_q;

  // Query field decode; the echoed fields are read straight from the buffer
  wire logic        idle      = (state_q == MRS_S_IDLE);
  wire logic [7:0]  q_func    = qbuf_q[1];
  wire logic [15:0] q_start   = {qbuf_q[2], qbuf_q[3]};  // R03
  wire logic [15:0] q_word    = {qbuf_q[4], qbuf_q[5]};  // R07
  wire logic        len_ok    = (rx_cnt_q == 9'(MRS_QRY_LEN));
  wire logic        addr_hit  = (qbuf_q[0] == slave_addr_i) || (qbuf_q[0] == MRS_BCAST_ADDR);
  wire logic        crc_ok    = (rx_crc.crc == 16'h0000);  // Residue over data plus check bytes
  wire logic        frame_ok  = !rx_bad_q && (rx_cnt_q >= 9'(MRS_MIN_LEN)) && crc_ok && addr_hit;
  wire logic        eof_act   = idle && rx_eof_i && (rx_cnt_q != 9'h000);
  wire logic        qty_bad   = (q_word == 16'h0000) || (q_word > 16'(MRS_MAX_REGS));
  wire logic [3:0]  rd_last   = 4'(q_word - 16'h0001);

  // Receive path feeds its engine only while idle; the engine restarts per frame
  assign rx_crc.clr  = idle && rx_eof_i;
  assign rx_crc.en   = idle && rx_valid_i && !rx_eof_i;
  assign rx_crc.data = rx_data_i;

  // Outgoing byte selection
  wire logic        tx_load   = (state_q == MRS_S_SEND) && (!tx_valid_q || tx_ready_i) && (tx_idx_q < tx_len_q);
  wire logic        in_body   = (tx_idx_q < 6'(tx_len_q - 6'h02));
  wire logic [5:0]  rd_off    = 6'(tx_idx_q - 6'h03);
  wire logic [15:0] rd_word   = rdbuf_q[rd_off[4:1]];
  wire logic [7:0]  rd_byte   = rd_off[0] ? rd_word[7:0] : rd_word[15:8];  // R04
  wire logic [7:0]  exc_byte  = (tx_idx_q == 6'h00) ? qbuf_q[0] :
                                (tx_idx_q == 6'h01) ? (q_func | MRS_EXC_FLAG) : exc_q;  // R12
  wire logic [7:0]  body_byte;
  wire logic [7:0]  next_byte;

  // Exception header first, else the flagged function code would be lost to the echo path
  assign body_byte = (mode_q == MRS_M_EXC) ? exc_byte :  // R11
                     (tx_idx_q < 6'h02) ? qbuf_q[tx_idx_q[2:0]] :
                     (mode_q == MRS_M_ECHO) ? qbuf_q[tx_idx_q[2:0]] :  // R10
                     (tx_idx_q == 6'h02) ? {q_word[6:0], 1'b0} : rd_byte;  // R04
  // Check field goes out low byte first
  assign next_byte = in_body ? body_byte :
                     (tx_idx_q == 6'(tx_len_q - 6'h02)) ? tx_crc.crc[7:0] : tx_crc.crc[15:8];  // R16

  assign tx_crc.clr  = (state_q != MRS_S_SEND);
  assign tx_crc.en   = tx_load && in_body;
  assign tx_crc.data = body_byte;

  // Receive buffering; bytes beyond the query length are counted but not stored
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rx_cnt_q <= 9'h000;
      rx_bad_q <= 1'b0;
      for (int i = 0; i < MRS_QRY_LEN; i++)
        qbuf_q[i] <= 8'h00;
    end
    else if (idle)
    begin
      if (rx_eof_i)
      begin
        rx_cnt_q <= 9'h000;
        rx_bad_q <= 1'b0;
      end
      else if (rx_valid_i)
      begin
        if (rx_cnt_q < 9'(MRS_QRY_LEN))
          qbuf_q[rx_cnt_q[2:0]] <= rx_data_i;
        if (rx_cnt_q != 9'h1ff)
          rx_cnt_q <= rx_cnt_q + 9'h001;
        if (rx_err_i || rx_cnt_q >= 9'(MRS_MAX_FRAME))
          rx_bad_q <= 1'b1;
      end
    end
  end

  // Query execution and response sequencing
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      state_q    <= MRS_S_IDLE;
      mode_q     <= MRS_M_ECHO;
      exc_q      <= 8'h00;
      bcast_q    <= 1'b0;
      rd_idx_q   <= 4'h0;
      tx_idx_q   <= 6'h00;
      tx_len_q   <= 6'h00;
      tx_valid_q <= 1'b0;
      tx_data_q  <= 8'h00;
      reg_rd_q   <= 1'b0;
      reg_wr_q   <= 1'b0;
      reg_addr_q <= 16'h0000;
      drop_q     <= 1'b0;
      busy_q     <= 1'b0;
      for (int i = 0; i < MRS_MAX_REGS; i++)
        rdbuf_q[i] <= 16'h0000;
    end
    else
    begin
      drop_q <= 1'b0;
      case (state_q)
        MRS_S_IDLE:
        begin
          tx_idx_q <= 6'h00;
          if (eof_act && !frame_ok)
            drop_q <= 1'b1;  // R15
          else if (eof_act)
          begin
            bcast_q <= (qbuf_q[0] == MRS_BCAST_ADDR);
            busy_q  <= 1'b1;
            state_q <= MRS_S_SEND;
            mode_q  <= MRS_M_EXC;
            tx_len_q <= MRS_EXC_LEN;
            if ((q_func == MRS_FC_READ || q_func == MRS_FC_WRITE || q_func == MRS_FC_DIAG) && !len_ok)
              exc_q <= MRS_EXC_BAD_DATA;
            else if (q_func == MRS_FC_READ && qty_bad)
              exc_q <= MRS_EXC_BAD_DATA;  // R14
            else if (q_func == MRS_FC_READ)
            begin
              state_q  <= MRS_S_RD;  // R01
              rd_idx_q <= 4'h0;
            end
            else if (q_func == MRS_FC_WRITE)
              state_q <= MRS_S_WR;  // R06
            else if (q_func == MRS_FC_DIAG && q_start != MRS_DIAG_ECHO_SUB)
              exc_q <= MRS_EXC_BAD_FUNC;  // R13
            else if (q_func == MRS_FC_DIAG)
            begin
              mode_q   <= MRS_M_ECHO;  // R09
              tx_len_q <= MRS_ECHO_LEN;
            end
            else
              exc_q <= MRS_EXC_BAD_FUNC;
          end
        end
        // One request per register, released for a cycle after each ack
        MRS_S_RD:
        begin
          if (!reg_rd_q)
          begin
            reg_rd_q   <= 1'b1;
            reg_addr_q <= 16'(q_start + {12'h000, rd_idx_q});  // R02
          end
          else if (reg_ack_i)
          begin
            reg_rd_q          <= 1'b0;
            rdbuf_q[rd_idx_q] <= reg_rdata_i;  // R02
            if (reg_err_i)
            begin
              state_q  <= MRS_S_SEND;
              mode_q   <= MRS_M_EXC;
              exc_q    <= MRS_EXC_SLAVE_ERR;
              tx_len_q <= MRS_EXC_LEN;
            end
            else if (rd_idx_q == rd_last)
            begin
              state_q  <= MRS_S_SEND;
              mode_q   <= MRS_M_READ;
              tx_len_q <= 6'(MRS_RD_HDR_LEN + {q_word[4:0], 1'b0});  // R04
            end
            else
              rd_idx_q <= rd_idx_q + 4'h1;
          end
        end
        MRS_S_WR:
        begin
          if (!reg_wr_q)
          begin
            reg_wr_q   <= 1'b1;
            reg_addr_q <= q_start;  // R06
          end
          else if (reg_ack_i)
          begin
            reg_wr_q <= 1'b0;
            state_q  <= MRS_S_SEND;
            mode_q   <= reg_err_i ? MRS_M_EXC : MRS_M_ECHO;  // R11
            exc_q    <= MRS_EXC_SLAVE_ERR;  // R11
            tx_len_q <= reg_err_i ? MRS_EXC_LEN : MRS_ECHO_LEN;
          end
        end
        // Broadcast queries are executed but never answered
        MRS_S_SEND:
        begin
          if (bcast_q)
          begin
            state_q <= MRS_S_IDLE;
            busy_q  <= 1'b0;
          end
          else if (tx_load)
          begin
            tx_valid_q <= 1'b1;
            tx_data_q  <= next_byte;
            tx_idx_q   <= tx_idx_q + 6'h01;
          end
          else if (!tx_valid_q || tx_ready_i)
          begin
            tx_valid_q <= 1'b0;
            state_q    <= MRS_S_IDLE;
            busy_q     <= 1'b0;
          end
        end
        default:
        begin
          state_q <= MRS_S_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  assign tx_valid_o  = tx_valid_q;
  assign tx_data_o   = tx_data_q;
  assign reg_rd_o    = reg_rd_q;
  assign reg_wr_o    = reg_wr_q;
  assign reg_addr_o  = reg_addr_q;
  assign reg_wdata_o = q_word;  // Held in the query buffer for the whole write
  assign busy_o      = busy_q;  // Own flop, set and cleared with every idle transition
  assign drop_o      = drop_q;
endmodule
